// ===== logic/uam_pkg.sv
// Constants for the receive address-match and character config block.
// Assumes a 32-bit AXI4-Lite register bus; each register is one word.
package uam_pkg;
    // Register indices; byte address is index times four
    localparam logic [5:0] IDX_DATA = 6'h07;
    localparam logic [5:0] IDX_MATCH_ONE = 6'h08;
    localparam logic [5:0] IDX_MATCH_TWO = 6'h09;
    localparam logic [5:0] IDX_CTRL = 6'h0a;
    localparam logic [5:0] IDX_STAT = 6'h0c;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;
    // Control register fields
    localparam int CTRL_MATCH_EN_ONE_BIT = 7;
    localparam int CTRL_MATCH_EN_TWO_BIT = 6;
    localparam int CTRL_TEN_SEL_BIT = 5;
    localparam int OVS_MSB = 4;
    localparam int OVS_LSB = 0;
    localparam logic [4:0] OVS_MIN = 5'h03;
    localparam logic [4:0] OVS_DEFAULT = 5'h0f;
    // Status register fields
    localparam int STAT_NOT_EMPTY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_OPEN_BIT = 2;
    localparam int STAT_RATIO_LSB = 8;
    localparam int STAT_RATIO_MSB = 13;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h0f;
    localparam logic [7:0] MATCH_RESET = 8'h00;
    localparam logic [5:0] RATIO_RESET = 6'h10;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Data path
    localparam int CHAR_W = 8;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic {FLT_CLOSED = 1'b0, FLT_OPEN = 1'b1} uam_flt_t;
endpackage : uam_pkg

// ===== logic/uam_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module uam_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_q];

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : uam_fifo
`default_nettype wire

// ===== logic/uam_top.sv
// Receive address-match filter, character format and oversampling config.
// Assumes received characters arrive from a receiver on the same clock,
// with the top bit of the character flagged separately.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module uam_top
    import uam_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Received characters
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_char,
    input wire logic rx_top_bit,
    // Configuration to shifters
    output logic ten_bit_char_select,
    output logic [5:0] ovs_ratio
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] match_address_one_q;
    logic [7:0] match_address_two_q;
    logic match_enable_one_q;
    logic match_enable_two_q;
    logic ten_bit_q;
    logic [4:0] ovs_field_q;
    logic [5:0] ovs_ratio_q;
    uam_flt_t flt_q;

    logic aw_have_q;
    logic w_have_q;
    logic [5:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic wr_go;
    logic wr_ctrl;
    logic rd_go;
    logic [5:0] ar_idx;
    logic [4:0] ovs_new;

    // ****************************************************************
    // Receive filter and buffer
    // ****************************************************************
    logic match_on;
    logic addr_hit;
    logic keep;
    logic rx_fire;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [CHAR_W-1:0] fifo_out_data;

    assign match_on = match_enable_one_q || match_enable_two_q;
    assign addr_hit = (match_enable_one_q
                       && rx_char == match_address_one_q)
                   || (match_enable_two_q
                       && rx_char == match_address_two_q);
    // Address compare only on top-bit characters; data follows state
    assign keep = !match_on
               || (rx_top_bit ? addr_hit
                              : (flt_q == FLT_OPEN));
    // Discards never stall the receiver
    assign rx_ready = keep ? fifo_in_ready : 1'b1;
    assign rx_fire = rx_valid && rx_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_q <= FLT_CLOSED;
        end else if (!match_on) begin
            flt_q <= FLT_CLOSED;
        end else if (rx_fire && rx_top_bit) begin
            flt_q <= addr_hit ? FLT_OPEN : FLT_CLOSED;
        end
    end

    uam_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(rx_valid && keep),
        .in_ready(fifo_in_ready),
        .in_data(rx_char),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    assign awready = !aw_have_q;
    assign wready = !w_have_q;
    assign arready = !rvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;
    assign wr_ctrl = wr_go && aw_idx_q == IDX_CTRL && wstrb0_q;
    assign rd_go = arvalid && !rvalid_q;
    assign ar_idx = araddr[IDX_MSB:IDX_LSB];
    assign fifo_pop = rd_go && ar_idx == IDX_DATA && fifo_out_valid;
    // Out-of-range ratio is replaced, so read-back shows what is used
    assign ovs_new = (wbyte_q[OVS_MSB:OVS_LSB] < OVS_MIN) ? OVS_DEFAULT
                   : wbyte_q[OVS_MSB:OVS_LSB];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= '0;
            wbyte_q <= '0;
            wstrb0_q <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= awaddr[IDX_MSB:IDX_LSB];
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wbyte_q <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_idx_q == IDX_MATCH_ONE
                        || aw_idx_q == IDX_MATCH_TWO
                        || aw_idx_q == IDX_CTRL) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Match addresses take writes even while enabled; safe use is
    // left to software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_address_one_q <= MATCH_RESET;
            match_address_two_q <= MATCH_RESET;
        end else if (wr_go && wstrb0_q) begin
            if (aw_idx_q == IDX_MATCH_ONE) begin
                match_address_one_q <= wbyte_q;
            end
            if (aw_idx_q == IDX_MATCH_TWO) begin
                match_address_two_q <= wbyte_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_enable_one_q <= CTRL_RESET[CTRL_MATCH_EN_ONE_BIT];
            match_enable_two_q <= CTRL_RESET[CTRL_MATCH_EN_TWO_BIT];
            ten_bit_q <= CTRL_RESET[CTRL_TEN_SEL_BIT];
            ovs_field_q <= CTRL_RESET[OVS_MSB:OVS_LSB];
            ovs_ratio_q <= RATIO_RESET;
        end else if (wr_ctrl) begin
            match_enable_one_q <= wbyte_q[CTRL_MATCH_EN_ONE_BIT];
            match_enable_two_q <= wbyte_q[CTRL_MATCH_EN_TWO_BIT];
            ten_bit_q <= wbyte_q[CTRL_TEN_SEL_BIT];
            ovs_field_q <= ovs_new;
            ovs_ratio_q <= {1'b0, ovs_new} + 6'h01;
        end
    end

    assign ten_bit_char_select = ten_bit_q;
    assign ovs_ratio = ovs_ratio_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
            unique case (ar_idx)
                IDX_DATA: begin
                    rdata_q[CHAR_W-1:0] <= fifo_out_valid ? fifo_out_data
                                                          : '0;
                end
                IDX_MATCH_ONE: begin
                    rdata_q[7:0] <= match_address_one_q;
                end
                IDX_MATCH_TWO: begin
                    rdata_q[7:0] <= match_address_two_q;
                end
                IDX_CTRL: begin
                    rdata_q[7:0] <= {match_enable_one_q, match_enable_two_q,
                                     ten_bit_q, ovs_field_q};
                end
                IDX_STAT: begin
                    rdata_q[STAT_NOT_EMPTY_BIT] <= fifo_out_valid;
                    rdata_q[STAT_FULL_BIT] <= !fifo_in_ready;
                    rdata_q[STAT_OPEN_BIT] <= (flt_q == FLT_OPEN);
                    rdata_q[STAT_RATIO_MSB:STAT_RATIO_LSB] <= ovs_ratio_q;
                end
                default: begin
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_no_filter_pass: assert property (
        !match_on && rx_valid |-> u_fifo.in_valid)
        else $error("unfiltered character not offered to buffer");
    a_one_miss_drop: assert property (
        match_enable_one_q && !match_enable_two_q && rx_valid
        && rx_top_bit && rx_char != match_address_one_q
        |-> !u_fifo.in_valid && rx_ready)
        else $error("address miss on first match kept");
    a_two_miss_drop: assert property (
        match_enable_two_q && !match_enable_one_q && rx_valid
        && rx_top_bit && rx_char != match_address_two_q
        |-> !u_fifo.in_valid && rx_ready)
        else $error("address miss on second match kept");
    a_hit_opens_data: assert property (
        match_on && rx_fire && rx_top_bit && addr_hit
        ##1 (match_on && rx_valid && !rx_top_bit)
        |-> u_fifo.in_valid)
        else $error("data after matched address dropped");
    a_miss_closes_data: assert property (
        match_on && rx_fire && rx_top_bit && !addr_hit
        ##1 (match_on && rx_valid && !rx_top_bit)
        |-> !u_fifo.in_valid)
        else $error("data after failed address kept");
    a_data_no_compare: assert property (
        match_on && rx_valid && !rx_top_bit && flt_q == FLT_OPEN
        |-> u_fifo.in_valid)
        else $error("data character compared against address");
    a_ten_bit_follows: assert property (
        wr_ctrl |=> ten_bit_char_select == $past(wbyte_q[CTRL_TEN_SEL_BIT]))
        else $error("ten-bit select not taken from write");
    a_ovs_fallback: assert property (
        wr_ctrl && wbyte_q[OVS_MSB:OVS_LSB] < OVS_MIN
        |=> ovs_field_q == OVS_DEFAULT && ovs_ratio == 6'h10)
        else $error("invalid ratio did not fall back to 16");
    a_ovs_range: assert property (
        ovs_ratio >= 6'h04 && ovs_ratio <= 6'h20
        && ovs_ratio == {1'b0, ovs_field_q} + 6'h01)
        else $error("oversampling ratio out of range");

    c_match_pass: cover property (
        match_on && rx_fire && rx_top_bit && addr_hit
        ##1 rx_fire && !rx_top_bit && keep);
    c_fifo_full: cover property (!fifo_in_ready && rx_valid);
    c_data_read: cover property (fifo_pop);
endmodule : uam_top
`default_nettype wire

// ===== tb/uam_node.sv
// Remote serial node model: offers received characters to the block.
// Assumes the block's clock; the bench fills the queue and may set slow.
`timescale 1ns/1ns
`default_nettype none
module uam_node (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Character stream
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_char,
    output logic rx_top_bit
);
    // ********************************
    // Offer queue
    // ********************************
    logic [8:0] q[$];
    logic slow = 1'b0;
    logic pause_q = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_char = 8'h00;
        rx_top_bit = 1'b0;
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_valid <= 1'b0;
        end else if (!rx_valid || rx_ready) begin
            if (q.size() > 0 && !(slow && !pause_q)) begin
                {rx_top_bit, rx_char} <= q.pop_front();
                rx_valid <= 1'b1;
                pause_q <= 1'b0;
            end else begin
                // Idle lines wander so stale data is never trusted
                rx_valid <= 1'b0;
                {rx_top_bit, rx_char} <= ~{rx_top_bit, rx_char};
                pause_q <= 1'b1;
            end
        end
    end
endmodule : uam_node
`default_nettype wire

// ===== tb/uam_addr_match_char_config_tb.sv
// Self-checking bench for the address-match and character config block.
// Assumes the node model feeds characters; registers over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module uam_addr_match_char_config_tb;
    import uam_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ma1;
        logic [7:0] ma2;
        logic [3:0] top;
        logic [31:0] ch;
        logic [3:0] keep;
    } uam_row_t;
    localparam logic [7:0] A_DATA = {IDX_DATA, 2'b00};
    localparam logic [7:0] A_MATCH_ONE = {IDX_MATCH_ONE, 2'b00};
    localparam logic [7:0] A_MATCH_TWO = {IDX_MATCH_TWO, 2'b00};
    localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
    localparam uam_row_t ROWS [7] = '{
        '{8'h0f, 8'h11, 8'h22, 4'b0101, 32'h14a312a1, 4'b1111},
        '{8'h83, 8'h5a, 8'h00, 4'b1010, 32'h33025a01, 4'b0110},
        '{8'h5f, 8'h5a, 8'h77, 4'b0101, 32'h0477035a, 4'b1100},
        '{8'he0, 8'h10, 8'h20, 4'b0101, 32'h06300520, 4'b0011},
        '{8'h21, 8'h00, 8'h00, 4'b1111, 32'h44332211, 4'b1111},
        '{8'h02, 8'h00, 8'h00, 4'b0000, 32'h88776655, 4'b1111},
        '{8'h9e, 8'h5a, 8'h00, 4'b1010, 32'h5a075b5a, 4'b1000}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] rx_char;
    logic rx_top_bit, ten_bit_char_select;
    logic [5:0] ovs_ratio;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #10 aclk = ~aclk;
    uam_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_char(rx_char),
        .rx_top_bit(rx_top_bit),
        .ten_bit_char_select(ten_bit_char_select), .ovs_ratio(ovs_ratio));
    uam_node node (.aclk(aclk), .aresetn(aresetn), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_char(rx_char), .rx_top_bit(rx_top_bit));
    // ********************************
    // Bus and run control
    // ********************************
    task automatic end_sim;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r, input logic [3:0] s = 4'h1);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Stops once the node queue is empty and its last character is either taken or stalled by a full buffer
    task automatic wait_idle;
        int n;
        n = 0;
        while (!(node.q.size() == 0 && (!rx_valid || !rx_ready))
               && n < 100) begin
            @(posedge aclk);
            n++;
        end
        // A node that never settles is a failure, not a pass
        if (n >= 100) begin
            err_count++;
            end_sim();
        end
    endtask : wait_idle
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] f;
        uam_row_t w;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CTRL, d, r);
        `CHK(d[7:0], CTRL_RESET)
        rd(A_MATCH_TWO, d, r);
        `CHK(d[7:0], 8'h00)
        `CHK(ovs_ratio, 6'h10)
        for (int i = 0; i < 7; i++) begin
            w = ROWS[i];
            node.slow = i[0];
            wr(A_CTRL, {24'h0, w.ctrl & 8'h3f}, r);
            wr(A_MATCH_ONE, {24'h0, w.ma1}, r);
            wr(A_MATCH_TWO, {24'h0, w.ma2}, r);
            wr(A_CTRL, {24'h0, w.ctrl}, r);
            `CHK(r, RESP_OKAY)
            f = (w.ctrl[4:0] < OVS_MIN) ? OVS_DEFAULT : w.ctrl[4:0];
            rd(A_CTRL, d, r);
            `CHK(d[7:0], {w.ctrl[7:5], f})
            `CHK(ten_bit_char_select, w.ctrl[5])
            `CHK(ovs_ratio, {1'b0, f} + 6'h01)
            rd(A_STAT, d, r);
            `CHK(d[13:8], {1'b0, f} + 6'h01)
            for (int k = 0; k < 4; k++) begin
                node.q.push_back({w.top[k], w.ch[8*k +: 8]});
            end
            wait_idle();
            // Filter is left open only if the last character was kept
            rd(A_STAT, d, r);
            `CHK(d[STAT_OPEN_BIT], (w.ctrl[7] | w.ctrl[6]) & w.keep[3])
            for (int k = 0; k < 4; k++) begin
                if (w.keep[k]) begin
                    rd(A_DATA, d, r);
                    `CHK(d[7:0], w.ch[8*k +: 8])
                end
            end
            rd(A_DATA, d, r);
            `CHK(d, 32'h0)
        end
        node.slow = 1'b0;
        wr(A_CTRL, 32'h0f, r);
        for (int k = 0; k < 5; k++) begin
            node.q.push_back({1'b0, 8'hc0 + 8'(k)});
        end
        wait_idle();
        `CHK(rx_ready, 1'b0)
        rd(A_STAT, d, r);
        `CHK(d[STAT_FULL_BIT], 1'b1)
        `CHK(d[STAT_NOT_EMPTY_BIT], 1'b1)
        // Stalled data char must now be dropped despite the full buffer
        wr(A_CTRL, 32'h8f, r);
        wait_idle();
        `CHK(rx_valid, 1'b0)
        for (int k = 0; k < 4; k++) begin
            rd(A_DATA, d, r);
            `CHK(d[7:0], 8'hc0 + 8'(k))
        end
        rd(A_DATA, d, r);
        `CHK(d, 32'h0)
        rd(8'h3c, d, r);
        `CHK(r, RESP_SLVERR)
        wr(8'h3c, 32'h1, r);
        `CHK(r, RESP_SLVERR)
        wr(A_STAT, 32'h1, r);
        `CHK(r, RESP_SLVERR)
        wr(A_MATCH_ONE, 32'h99, r);
        `CHK(r, RESP_OKAY)
        // Lane 0 strobe low: answered, but the register keeps its value
        wr(A_MATCH_ONE, 32'h55, r, 4'h0);
        `CHK(r, RESP_OKAY)
        rd(A_MATCH_ONE, d, r);
        `CHK(d[7:0], 8'h99)
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_MATCH_ONE, d, r);
        `CHK(d[7:0], MATCH_RESET)
        `CHK(ovs_ratio, RATIO_RESET)
        end_sim();
    end
endmodule : uam_addr_match_char_config_tb
`default_nettype wire
